// file: rtl/rre_pkg.sv
// Constants and types for the return and rotate execution slice
`default_nettype none
package rre_pkg;
    // Instruction word and field layout (14-bit core word)
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 13;
    localparam int DEST_BIT = 7;
    localparam int LIT_LSB = 0;
    localparam int FADDR_LSB = 0;
    // Opcode encodings
    localparam logic [13:0] OP_INTERRUPT_RETURN = 14'h0009;
    localparam logic [13:0] OP_SUB_RETURN = 14'h0008;
    localparam logic [5:0] OP_LITERAL_RETURN_HI = 6'h0d;
    localparam logic [5:0] OP_ROTATE_LEFT_HI = 6'h0d;
    localparam logic [5:0] OP_ROTATE_RIGHT_HI = 6'h0c;
    localparam logic [3:0] OP_LIT_RET_TOP = 4'hd;
    localparam logic [1:0] OP_LIT_RET_PREFIX = 2'h3;
    // Interrupt control register: global enable position
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    // Cycle counts
    localparam int RETURN_CYCLES = 2;
    localparam int ROTATE_CYCLES = 1;
    // Reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;

    typedef enum logic [1:0] {
        RRE_IDLE = 2'b00,
        RRE_RET2 = 2'b01
    } rre_state_t;

    typedef enum logic [2:0] {
        RRE_K_NONE = 3'b000,
        RRE_K_IRET = 3'b001,
        RRE_K_LRET = 3'b010,
        RRE_K_SRET = 3'b011,
        RRE_K_RLC = 3'b100,
        RRE_K_RRC = 3'b101
    } rre_kind_t;
endpackage
`default_nettype wire

// file: rtl/rre_rotator.sv
// Rotate-through-carry datapath slice
`timescale 1ns/1ns
`default_nettype none
module rre_rotator
    import rre_pkg::*;
(
    // Operands
    input wire logic i_left,
    input wire logic [7:0] i_value,
    input wire logic i_carry,
    // Results
    output logic [7:0] o_result,
    output logic o_carry
);
    always_comb
    begin
        if (i_left)
        begin
            o_result = {i_value[6:0], i_carry};
            o_carry = i_value[7];
        end
        else
        begin
            o_result = {i_carry, i_value[7:1]};
            o_carry = i_value[0];
        end
    end
endmodule
`default_nettype wire

// file: rtl/rre_exec.sv
// Return and rotate-through-carry instruction execution
`timescale 1ns/1ns
`default_nettype none
module rre_exec
    import rre_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // Instruction issue
    input wire logic i_valid,
    input wire logic [13:0] i_insn,
    // Core state inputs
    input wire logic [12:0] i_stack_top_value,
    input wire logic [7:0] i_file_rdata,
    input wire logic i_carry,
    // Handshake and core updates
    output logic o_busy,
    output logic o_done,
    output logic o_unsupported,
    output logic o_stack_pop,
    output logic o_pc_load,
    output logic [12:0] o_pc,
    output logic o_acc_we,
    output logic [7:0] o_acc,
    output logic o_file_we,
    output logic [6:0] o_file_addr,
    output logic [7:0] o_file_wdata,
    output logic o_carry_we,
    output logic o_carry,
    output logic o_global_irq_enable_set
);
    typedef struct packed {
        rre_state_t state;
        logic busy;
        logic done;
        logic unsupported;
        logic stack_pop;
        logic pc_load;
        logic [12:0] pc;
        logic acc_we;
        logic [7:0] acc;
        logic file_we;
        logic [6:0] file_addr;
        logic [7:0] file_wdata;
        logic carry_we;
        logic carry;
        logic gie_set;
    } rre_regs_t;

    rre_regs_t r;
    rre_regs_t next_r;
    rre_kind_t kind;
    logic [7:0] rot_result;
    logic rot_carry;

    function automatic rre_kind_t decode(input logic [13:0] insn);
        if (insn == OP_INTERRUPT_RETURN)
            return RRE_K_IRET;
        if (insn == OP_SUB_RETURN)
            return RRE_K_SRET;
        if (insn[13:10] == OP_LIT_RET_TOP)
            return RRE_K_LRET;
        if (insn[13:8] == OP_ROTATE_LEFT_HI)
            return RRE_K_RLC;
        if (insn[13:8] == OP_ROTATE_RIGHT_HI)
            return RRE_K_RRC;
        return RRE_K_NONE;
    endfunction

    assign kind = decode(i_insn);

    rre_rotator u_rot (
        .i_left(kind == RRE_K_RLC),
        .i_value(i_file_rdata),
        .i_carry(i_carry),
        .o_result(rot_result),
        .o_carry(rot_carry)
    );

    always_comb
    begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.unsupported = 1'b0;
        next_r.stack_pop = 1'b0;
        next_r.pc_load = 1'b0;
        next_r.acc_we = 1'b0;
        next_r.file_we = 1'b0;
        next_r.carry_we = 1'b0;
        next_r.gie_set = 1'b0;
        case (r.state)
            RRE_IDLE:
            begin
                if (i_valid)
                begin
                    case (kind)
                        RRE_K_IRET, RRE_K_SRET, RRE_K_LRET:
                        begin
                            // Pop now; second cycle is the refill bubble
                            next_r.state = RRE_RET2;
                            next_r.busy = 1'b1;
                            next_r.stack_pop = 1'b1;
                            next_r.pc_load = 1'b1;
                            next_r.pc = i_stack_top_value;
                            if (kind == RRE_K_IRET)
                                next_r.gie_set = 1'b1;
                            if (kind == RRE_K_LRET)
                            begin
                                next_r.acc_we = 1'b1;
                                next_r.acc = i_insn[7:0];
                            end
                        end
                        RRE_K_RLC, RRE_K_RRC:
                        begin
                            next_r.done = 1'b1;
                            next_r.carry_we = 1'b1;
                            next_r.carry = rot_carry;
                            if (i_insn[DEST_BIT])
                            begin
                                next_r.file_we = 1'b1;
                                next_r.file_addr = i_insn[6:0];
                                next_r.file_wdata = rot_result;
                            end
                            else
                            begin
                                next_r.acc_we = 1'b1;
                                next_r.acc = rot_result;
                            end
                        end
                        default:
                        begin
                            next_r.unsupported = 1'b1;
                        end
                    endcase
                end
            end
            RRE_RET2:
            begin
                next_r.state = RRE_IDLE;
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end
            default:
            begin
                next_r.state = RRE_IDLE;
                next_r.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            r <= '0;
            r.state <= RRE_IDLE;
            r.acc <= ACC_RESET;
            r.pc <= PC_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign o_busy = r.busy;
    assign o_done = r.done;
    assign o_unsupported = r.unsupported;
    assign o_stack_pop = r.stack_pop;
    assign o_pc_load = r.pc_load;
    assign o_pc = r.pc;
    assign o_acc_we = r.acc_we;
    assign o_acc = r.acc;
    assign o_file_we = r.file_we;
    assign o_file_addr = r.file_addr;
    assign o_file_wdata = r.file_wdata;
    assign o_carry_we = r.carry_we;
    assign o_carry = r.carry;
    assign o_global_irq_enable_set = r.gie_set;

    AST_IRET_GIE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (r.state == RRE_IDLE && i_valid && kind == RRE_K_IRET)
        |=> o_global_irq_enable_set && o_pc_load ##1 o_done)
        else $error("interrupt return did not set enable");
    AST_IRET_PC: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (r.state == RRE_IDLE && i_valid && kind == RRE_K_IRET)
        |=> o_pc == $past(i_stack_top_value) && o_stack_pop)
        else $error("interrupt return pc wrong");
    AST_LRET_ACC: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (r.state == RRE_IDLE && i_valid && kind == RRE_K_LRET)
        |=> o_acc_we && o_acc == $past(i_insn[7:0]))
        else $error("literal return accumulator wrong");
    AST_LRET_TWO: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (r.state == RRE_IDLE && i_valid && kind == RRE_K_LRET)
        |=> o_busy && o_pc_load && !o_done ##1 o_done && !o_busy)
        else $error("literal return not two cycles");
    AST_SRET_FLAGS: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (r.state == RRE_IDLE && i_valid && kind == RRE_K_SRET)
        |=> !o_carry_we && !o_acc_we && !o_global_irq_enable_set
        && o_stack_pop ##1 o_done)
        else $error("subroutine return changed state");
    AST_RLC: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (r.state == RRE_IDLE && i_valid && kind == RRE_K_RLC)
        |=> o_carry == $past(i_file_rdata[7]) && o_carry_we && o_done
        && !o_pc_load)
        else $error("rotate left carry wrong");
    AST_RRC: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (r.state == RRE_IDLE && i_valid && kind == RRE_K_RRC)
        |=> o_carry == $past(i_file_rdata[0]) && o_carry_we)
        else $error("rotate right carry wrong");
    AST_DEST: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (r.state == RRE_IDLE && i_valid && kind == RRE_K_RLC)
        |=> (o_file_we == $past(i_insn[7])) && (o_acc_we != o_file_we))
        else $error("rotate destination wrong");
    AST_RRC_DATA: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (r.state == RRE_IDLE && i_valid && kind == RRE_K_RRC && !i_insn[7])
        |=> o_acc == {$past(i_carry), $past(i_file_rdata[7:1])})
        else $error("rotate right data wrong");

    COV_IRET: cover property (@(posedge i_clk) disable iff (!i_resetn)
        o_global_irq_enable_set ##1 o_done);
    COV_LRET: cover property (@(posedge i_clk) disable iff (!i_resetn)
        o_acc_we && o_pc_load);
    COV_ROT_FILE: cover property (@(posedge i_clk) disable iff (!i_resetn)
        o_file_we && o_carry_we);
endmodule
`default_nettype wire

// file: tb/rre_exec_tb.sv
// Self-checking bench for the return and rotate execution slice
`timescale 1ns/1ns
`default_nettype none
module rre_exec_tb;
    import rre_pkg::*;
    logic i_clk;
    logic i_resetn;
    logic i_valid;
    logic [13:0] i_insn;
    logic [12:0] i_stack_top_value;
    logic [7:0] i_file_rdata;
    logic i_carry;
    logic o_busy, o_done, o_unsupported, o_stack_pop, o_pc_load;
    logic [12:0] o_pc;
    logic o_acc_we, o_file_we, o_carry_we, o_carry;
    logic [7:0] o_acc;
    logic [6:0] o_file_addr;
    logic [7:0] o_file_wdata;
    logic o_global_irq_enable_set;
    int fail_count = 0;
    int n_tests = 0;

    rre_exec uut (
        .i_clk, .i_resetn, .i_valid, .i_insn, .i_stack_top_value,
        .i_file_rdata, .i_carry, .o_busy, .o_done, .o_unsupported,
        .o_stack_pop, .o_pc_load, .o_pc, .o_acc_we, .o_acc, .o_file_we,
        .o_file_addr, .o_file_wdata, .o_carry_we, .o_carry,
        .o_global_irq_enable_set
    );

    task automatic chk(input string what, input logic [12:0] exp,
                       input logic [12:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    task automatic issue(input logic [13:0] insn, input logic [12:0] stv,
                         input logic [7:0] fd, input logic c);
        @(posedge i_clk);
        i_valid <= 1'b1;
        i_insn <= insn;
        i_stack_top_value <= stv;
        i_file_rdata <= fd;
        i_carry <= c;
    endtask

    task automatic t_ret(input logic [13:0] insn, input logic [12:0] stv,
                         input logic acc_we, input logic [7:0] k,
                         input logic irq);
        issue(insn, stv, 8'h5a, 1'b1);
        // Rotate offered while busy must be dropped
        issue({OP_ROTATE_LEFT_HI, 8'h05}, 13'h0000, 8'hff, 1'b1);
        #1;
        chk("stack_pop", 13'h0001, 13'(o_stack_pop));
        chk("pc_load", 13'h0001, 13'(o_pc_load));
        chk("pc", stv, o_pc);
        chk("busy", 13'h0001, 13'(o_busy));
        chk("acc_we", 13'(acc_we), 13'(o_acc_we));
        if (acc_we)
            chk("acc", 13'(k), 13'(o_acc));
        chk("irq_set", 13'(irq), 13'(o_global_irq_enable_set));
        chk("carry_we", 13'h0000, 13'(o_carry_we));
        chk("done early", 13'h0000, 13'(o_done));
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
        chk("done", 13'h0001, 13'(o_done));
        chk("busy end", 13'h0000, 13'(o_busy));
        chk("refused carry_we", 13'h0000, 13'(o_carry_we));
        chk("refused acc_we", 13'h0000, 13'(o_acc_we));
    endtask

    // Four rotates back to back, both directions and destinations
    task automatic t_rot();
        // Accumulator results kept non-zero so a missed write shows
        logic [7:0] va [4] = '{8'hc0, 8'h01, 8'h03, 8'ha5};
        logic [6:0] fa [4] = '{7'h7f, 7'h00, 7'h2a, 7'h7f};
        logic [3:0] ca = 4'b1010;
        logic [8:0] exp;
        int i;
        int j;
        for (i = 0; i <= 4; i++)
        begin
            if (i < 4)
                issue({(i < 2) ? OP_ROTATE_LEFT_HI : OP_ROTATE_RIGHT_HI,
                       i[0], fa[i]}, 13'h0000, va[i], ca[i]);
            else
            begin
                @(posedge i_clk);
                i_valid <= 1'b0;
            end
            if (i > 0)
            begin
                #1;
                j = i - 1;
                if (j < 2)
                    exp = {va[j][7], va[j][6:0], ca[j]};
                else
                    exp = {va[j][0], ca[j], va[j][7:1]};
                chk("rot done", 13'h0001, 13'(o_done));
                chk("carry_we", 13'h0001, 13'(o_carry_we));
                chk("carry", 13'(exp[8]), 13'(o_carry));
                chk("rot pc_load", 13'h0000, 13'(o_pc_load));
                chk("acc_we", j[0] ? 13'h0000 : 13'h0001,
                    13'(o_acc_we));
                chk("file_we", 13'(j[0]), 13'(o_file_we));
                chk("result", 13'(exp[7:0]),
                    13'(j[0] ? o_file_wdata : o_acc));
                if (j[0])
                    chk("file_addr", 13'(fa[j]), 13'(o_file_addr));
            end
        end
    endtask

    task automatic t_unsup();
        issue(14'h0000, 13'h0000, 8'h00, 1'b0);
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
        chk("unsupported", 13'h0001, 13'(o_unsupported));
        chk("unsupported done", 13'h0000, 13'(o_done));
    endtask

    // Reset lands just after the edge that takes a return, in the refill cycle; all must clear
    task automatic t_reset();
        issue(OP_INTERRUPT_RETURN, 13'h0123, 8'h00, 1'b0);
        @(posedge i_clk);
        i_valid <= 1'b0;
        i_resetn <= 1'b0;
        #1;
        chk("reset busy", 13'h0000, 13'(o_busy));
        chk("reset pc", PC_RESET, o_pc);
        chk("reset acc", 13'(ACC_RESET), 13'(o_acc));
        chk("reset pc_load", 13'h0000, 13'(o_pc_load));
        @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        #1;
        chk("post-reset done", 13'h0000, 13'(o_done));
        chk("post-reset busy", 13'h0000, 13'(o_busy));
    endtask

    task automatic stop_test();
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // Whole sequence needs well under 100 cycles
    initial
    begin
        #16000;
        fail_count++;
        stop_test();
    end

    initial
    begin
        i_resetn = 1'b0;
        i_valid = 1'b0;
        i_insn = 14'h0000;
        i_stack_top_value = 13'h0000;
        i_file_rdata = 8'h00;
        i_carry = 1'b0;
        repeat (6) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_ret(OP_INTERRUPT_RETURN, 13'h1fff, 1'b0, 8'h00, 1'b1);
        t_ret({OP_LIT_RET_TOP, 2'b00, 8'hff}, 13'h1555, 1'b1, 8'hff,
              1'b0);
        t_ret({OP_LIT_RET_TOP, 2'b00, 8'h00}, 13'h0000, 1'b1, 8'h00,
              1'b0);
        t_ret(OP_SUB_RETURN, 13'h0abc, 1'b0, 8'h00, 1'b0);
        t_rot();
        t_unsup();
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
